// File: design/probe_port_pkg.sv
package probe_port_pkg;

  // ------------------------------------------------------------
  // strap encoding for chip select choice
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_ONE      = 2'h0;  // first host select
  localparam logic [1:0] SEL_TWO      = 2'h1;  // second host select
  localparam logic [1:0] SEL_THREE    = 2'h2;  // third host select
  localparam logic [1:0] SEL_COMBINED = 2'h3;  // combined host select

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam int          ADDR_W            = 20;     // host address width
  localparam int          SEG_LOW_W         = 8;      // 256 byte window
  localparam int          SEG_HIGH_W        = ADDR_W - SEG_LOW_W;
  localparam logic [7:0]  REACTIVATE_OFFSET = 8'h00;  // segment base
  localparam logic [7:0]  DEACTIVATE_OFFSET = 8'h04;  // base plus four
  localparam logic [7:0]  TRIGGER_SPACING   = 8'h04;  // one word per trigger
  localparam int          TRIGGER_COUNT     = 32;     // direct triggers

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;                 // 10 MHz system clock
  localparam int INIT_TIME_US   = 30;                  // own initialization time
  localparam int INIT_CYCLES    = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CNT_W     = 12;                  // counter width
  localparam int SENSE_FILTER   = 4;                   // stable samples for supply

  // ------------------------------------------------------------
  // bundled host bus strobes
  // ------------------------------------------------------------
  typedef struct packed {
    logic              select_one_n;       // host select 1, active low
    logic              select_two_n;       // host select 2, active low
    logic              select_three_n;     // host select 3, active low
    logic              select_combined_n;  // combined host select, active low
    logic              write_n;            // write strobe, active low
    logic              read_n;             // read strobe, active low
    logic [ADDR_W-1:0] addr;               // host address
  } host_bus_type;

endpackage

// File: design/supply_sense_filter.sv
`timescale 1ns/1ps
module supply_sense_filter
  import probe_port_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic sense_in,
  output logic      supply_on
);

  // ------------------------------------------------------------
  // debounce: level must hold for several samples
  // ------------------------------------------------------------
  logic [2:0] stable_reg;   // count of samples differing from accepted level
  logic [2:0] stable_next;
  logic       level_reg;    // accepted level
  logic       level_next;

  // next state: restart count whenever raw input agrees with accepted level
  always_comb begin
    stable_next = stable_reg;
    level_next  = level_reg;
    if (sense_in == level_reg) begin
      stable_next = 3'h0;
    end else if (stable_reg == 3'(SENSE_FILTER - 1)) begin
      level_next  = sense_in;
      stable_next = 3'h0;
    end else begin
      stable_next = stable_reg + 3'h1;
    end
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stable_reg <= 3'h0;
      level_reg  <= 1'b0;
    end else begin
      stable_reg <= stable_next;
      level_reg  <= level_next;
    end
  end

  assign supply_on = level_reg;

endmodule // supply_sense_filter

// File: design/probe_port_control.sv
// Function
// - answer only the strapped host select
// - no response while select negated
// - write at base plus four means deactivation
// - write at segment base means reactivation
// - write data value is ignored
// - notice addresses get no write protection
// - sense ecu supply, report on/off
// - power save when ecu off, tool absent
// - derive write protect from host resets
// - hold ecu reset throughout power save
// - hold ecu reset until initialization done
// - ecu reset on command or failure
// - decode aligned 256 byte trigger segment
`timescale 1ns/1ps
module probe_port_control
  import probe_port_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [1:0]            select_strap,          // board strap choice
  input  wire host_bus_type          host_bus,              // host bus strobes
  input  wire logic [SEG_HIGH_W-1:0] trigger_segment_base,  // segment address
  input  wire logic                  ecu_supply_sense,      // ecu supply level
  input  wire logic                  host_power_on_reset_n, // host power-on reset
  input  wire logic                  host_hard_reset_n,     // host hard reset
  input  wire logic                  tool_connected,        // calibration tool link up
  input  wire logic                  tool_reset_request,    // tool asks ecu reset
  input  wire logic                  internal_failure,      // probe fault detected
  output logic                       probe_selected,        // access is for us
  output logic                       deactivate_notice,     // pulse to tool
  output logic                       reactivate_notice,     // pulse to tool
  output logic [TRIGGER_COUNT-1:0]   trigger_pulse,         // acquisition starts
  output logic                       probe_active,          // last notice state
  output logic                       ecu_powered,           // supply state to tool
  output logic                       power_save,            // save mode active
  output logic                       memory_write_protect,  // emulation memory lock
  output logic                       memory_write_enable,   // qualified host write
  output logic                       ecu_reset_out,         // ecu reset drive
  output logic                       ecu_reset_oe           // open drain enable
);

  // ------------------------------------------------------------
  // chip select choice
  // ------------------------------------------------------------
  logic [1:0] strap_reg, strap_next;            // strap caught after reset release
  logic       strap_seen_reg, strap_seen_next;  // strap already taken
  logic       sel_raw;     // chosen select, active high

  // strap taken on the first edge after reset, then frozen so a
  // loose bridge cannot move the select in mid-run
  always_comb begin
    strap_next      = strap_reg;
    strap_seen_next = 1'b1;
    if (!strap_seen_reg) begin
      strap_next = select_strap;
    end
  end

  // strap registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg      <= SEL_ONE;
      strap_seen_reg <= 1'b0;
    end else begin
      strap_reg      <= strap_next;
      strap_seen_reg <= strap_seen_next;
    end
  end

  // pick the one strapped select
  always_comb begin
    case (strap_reg)
      SEL_ONE:      sel_raw = !host_bus.select_one_n;
      SEL_TWO:      sel_raw = !host_bus.select_two_n;
      SEL_THREE:    sel_raw = !host_bus.select_three_n;
      SEL_COMBINED: sel_raw = !host_bus.select_combined_n;
      default:      sel_raw = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic       seg_hit;     // address inside trigger segment
  logic       wr_now;      // selected write strobe low
  logic       wr_prev_reg; // previous strobe level for edge
  logic       wr_start;    // first cycle of a write
  logic [7:0] seg_off;     // offset in segment

  assign seg_hit  = host_bus.addr[ADDR_W-1:SEG_LOW_W] == trigger_segment_base;
  assign seg_off  = host_bus.addr[SEG_LOW_W-1:0];
  assign wr_now   = sel_raw && !host_bus.write_n;
  assign wr_start = wr_now && !wr_prev_reg;        // data lines never looked at

  // ------------------------------------------------------------
  // event and state registers
  // ------------------------------------------------------------
  logic                     deact_reg, deact_next;
  logic                     react_reg, react_next;
  logic                     active_reg, active_next;
  logic [TRIGGER_COUNT-1:0] trig_reg, trig_next;
  logic                     sel_reg, sel_next;

  // notices are plain address hits, no unlock sequence
  always_comb begin
    deact_next  = 1'b0;
    react_next  = 1'b0;
    active_next = active_reg;
    trig_next   = '0;
    sel_next    = sel_raw;  // drops at once when select negated
    if (wr_start && seg_hit) begin
      if (seg_off == DEACTIVATE_OFFSET) begin
        deact_next  = 1'b1;
        active_next = 1'b0;
      end
      if (seg_off == REACTIVATE_OFFSET) begin
        react_next  = 1'b1;
        active_next = 1'b1;
      end
      // trigger slots share the segment with the notices
      for (int i = 0; i < TRIGGER_COUNT; i++) begin
        if (seg_off == 8'(i * TRIGGER_SPACING)) begin
          trig_next[i] = 1'b1;
        end
      end
    end
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_reg <= 1'b0;
      deact_reg   <= 1'b0;
      react_reg   <= 1'b0;
      active_reg  <= 1'b1;
      trig_reg    <= '0;
      sel_reg     <= 1'b0;
    end else begin
      wr_prev_reg <= wr_now;
      deact_reg   <= deact_next;
      react_reg   <= react_next;
      active_reg  <= active_next;
      trig_reg    <= trig_next;
      sel_reg     <= sel_next;
    end
  end

  // ------------------------------------------------------------
  // supply sensing
  // ------------------------------------------------------------
  logic supply_on;  // debounced supply level

  supply_sense_filter u_sense (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .sense_in  (ecu_supply_sense),
    .supply_on (supply_on)
  );

  // ------------------------------------------------------------
  // power and reset sequencing
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT  = 3'b001,  // initializing, ecu held
    ST_RUN   = 3'b010,  // ecu released
    ST_SAVE  = 3'b100   // power save, ecu held
  } pwr_state_type;

  pwr_state_type          state_reg, state_next;
  logic [INIT_CNT_W-1:0]  init_cnt_reg, init_cnt_next;
  logic                   rst_drive_reg, rst_drive_next;
  logic                   wp_reg, wp_next;
  logic                   wen_reg, wen_next;

  // init runs after power-up and after every save exit
  always_comb begin
    state_next    = state_reg;
    init_cnt_next = init_cnt_reg;
    case (state_reg)
      ST_INIT: begin
        if (!supply_on && !tool_connected) begin
          state_next = ST_SAVE;
        end else if (init_cnt_reg == INIT_CNT_W'(INIT_CYCLES - 1)) begin
          state_next = ST_RUN;
        end else begin
          init_cnt_next = init_cnt_reg + 1'b1;
        end
      end
      ST_RUN: begin
        if (!supply_on && !tool_connected) begin
          state_next = ST_SAVE;
        end
      end
      ST_SAVE: begin
        init_cnt_next = '0;
        if (supply_on || tool_connected) begin
          state_next = ST_INIT;
        end
      end
      default: begin
        state_next    = ST_INIT;
        init_cnt_next = '0;
      end
    endcase
    // held in save and init, plus tool command or fault
    rst_drive_next = (state_next != ST_RUN) || tool_reset_request || internal_failure;
    // either host reset locks the memory
    wp_next  = !host_power_on_reset_n || !host_hard_reset_n;
    wen_next = wr_now && !wp_next;
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_INIT;
      init_cnt_reg  <= '0;
      rst_drive_reg <= 1'b1;
      wp_reg        <= 1'b1;
      wen_reg       <= 1'b0;
    end else begin
      state_reg     <= state_next;
      init_cnt_reg  <= init_cnt_next;
      rst_drive_reg <= rst_drive_next;
      wp_reg        <= wp_next;
      wen_reg       <= wen_next;
    end
  end

  // ------------------------------------------------------------
  // outputs from flip-flops, except ecu_reset_out tied low
  // ------------------------------------------------------------
  assign probe_selected       = sel_reg;
  assign deactivate_notice    = deact_reg;
  assign reactivate_notice    = react_reg;
  assign trigger_pulse        = trig_reg;
  assign probe_active         = active_reg;
  assign ecu_powered          = supply_on;
  assign power_save           = state_reg[2];  // one-hot save bit
  assign memory_write_protect = wp_reg;
  assign memory_write_enable  = wen_reg;
  assign ecu_reset_out        = 1'b0;          // open drain only pulls low
  assign ecu_reset_oe         = rst_drive_reg;

endmodule // probe_port_control

// File: tb/probe_port_properties.sv
`timescale 1ns/1ps
module probe_port_properties
  import probe_port_pkg::*;
(
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire logic                     ecu_supply_sense,
  input wire logic                     host_power_on_reset_n,
  input wire logic                     host_hard_reset_n,
  input wire logic                     tool_connected,
  input wire logic                     tool_reset_request,
  input wire logic                     internal_failure,
  input wire logic                     probe_selected,
  input wire logic                     deactivate_notice,
  input wire logic                     reactivate_notice,
  input wire logic [TRIGGER_COUNT-1:0] trigger_pulse,
  input wire logic                     probe_active,
  input wire logic                     ecu_powered,
  input wire logic                     power_save,
  input wire logic                     memory_write_protect,
  input wire logic                     memory_write_enable,
  input wire logic                     ecu_reset_out,
  input wire logic                     ecu_reset_oe
);
  // ------------------------------------------------------------
  // one domain: shared clock and reset
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // either host reset line low
  sequence s_host_rst; !host_power_on_reset_n || !host_hard_reset_n; endsequence
  // long enough to beat the four sample filter
  sequence s_supply_up; ecu_supply_sense [*6]; endsequence
  sequence s_supply_down; !ecu_supply_sense [*6]; endsequence
  // nobody keeps the ecu alive
  sequence s_ecu_idle; (!ecu_powered && !tool_connected) [*3]; endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_protect_on_rst: assert property (s_host_rst |=> memory_write_protect)
    else $error("write protect missing during host reset");
  a_unselected_quiet: assert property (!probe_selected |-> !(memory_write_enable ||
      deactivate_notice || reactivate_notice || (|trigger_pulse))) else $error("unselected response");
  a_deact_pulse: assert property (deactivate_notice |-> !probe_active && trigger_pulse[1]
      ##1 !deactivate_notice) else $error("deactivate notice malformed");
  a_react_pulse: assert property (reactivate_notice |-> probe_active && trigger_pulse[0]
      ##1 !reactivate_notice) else $error("reactivate notice malformed");
  a_one_trigger: assert property ($onehot0(trigger_pulse))
    else $error("several triggers at once");
  a_save_holds_rst: assert property (power_save |-> ecu_reset_oe && !ecu_reset_out)
    else $error("ecu reset not driven in save mode");
  a_cmd_reset: assert property ((tool_reset_request || internal_failure) |=> ecu_reset_oe)
    else $error("commanded ecu reset missing");
  a_init_hold: assert property ($rose(rst_n) |-> ecu_reset_oe [*8])
    else $error("ecu reset released too early");
  a_supply_up: assert property (s_supply_up |=> ecu_powered)
    else $error("supply on not reported");
  a_supply_down: assert property (s_supply_down |=> !ecu_powered)
    else $error("supply off not reported");
  a_save_entry: assert property (s_ecu_idle |=> power_save)
    else $error("save mode not entered");
endmodule // probe_port_properties

bind probe_port_control probe_port_properties u_props (.clk_sys, .rst_n, .ecu_supply_sense,
  .host_power_on_reset_n, .host_hard_reset_n, .tool_connected, .tool_reset_request,
  .internal_failure, .probe_selected, .deactivate_notice, .reactivate_notice, .trigger_pulse,
  .probe_active, .ecu_powered, .power_save, .memory_write_protect, .memory_write_enable,
  .ecu_reset_out, .ecu_reset_oe);

// File: tb/host_mcu_model.sv
`timescale 1ns/1ps
module host_mcu_model
  import probe_port_pkg::*;
(
  input  wire logic   clk_sys,
  output host_bus_type host_bus
);
  // parked bus: no select, no strobe
  initial host_bus = '1;
  // ------------------------------------------------------------
  // one write cycle; mask bit 3 is select one, bit 0 combined
  // ------------------------------------------------------------
  task automatic write_cycle(input logic [3:0] sel_mask, input logic [ADDR_W-1:0] addr);
    @(posedge clk_sys) #1;
    // select comes with the write and leaves with it
    {host_bus.select_one_n, host_bus.select_two_n, host_bus.select_three_n,
     host_bus.select_combined_n} = ~sel_mask;
    host_bus.write_n = 1'b0; // data carries nothing useful
    host_bus.addr = addr;
    @(posedge clk_sys) #1;
    // released address shows garbage, not the old value
    host_bus.addr = ~addr;
    {host_bus.select_one_n, host_bus.select_two_n, host_bus.select_three_n,
     host_bus.select_combined_n, host_bus.write_n} = '1;
  endtask
endmodule // host_mcu_model

// File: tb/emulator_probe_ecu_port_control_tb_top.sv
`timescale 1ns/1ps
module emulator_probe_ecu_port_control_tb_top
  import probe_port_pkg::*;
;
  logic                     clk_sys = 1'b0;
  logic                     rst_n   = 1'b0;
  logic [1:0]               strap   = 2'h0;
  logic [SEG_HIGH_W-1:0]    seg     = '0;
  logic                     supply  = 1'b1;
  logic                     por_n   = 1'b1;
  logic                     hard_n  = 1'b1;
  logic                     tool_on = 1'b1;
  logic                     tool_req = 1'b0;
  logic                     fail    = 1'b0;
  host_bus_type             host_bus;
  logic                     sel, deact, react, active, powered, save, wprot, wen, rst_out, rst_oe;
  logic [TRIGGER_COUNT-1:0] trig;
  logic [33:0]              exp_q[$];               // expected {deact, react, triggers}
  int                       err_total = 0;
  int                       total_checks = 0;
  int                       we_cnt = 0;             // qualified write cycles seen
  logic [31:0]              lfsr = 32'h000102fc;

  always #50 clk_sys = ~clk_sys;

  probe_port_control uut (.clk_sys(clk_sys), .rst_n(rst_n), .select_strap(strap),
    .host_bus(host_bus), .trigger_segment_base(seg), .ecu_supply_sense(supply),
    .host_power_on_reset_n(por_n), .host_hard_reset_n(hard_n), .tool_connected(tool_on),
    .tool_reset_request(tool_req), .internal_failure(fail), .probe_selected(sel),
    .deactivate_notice(deact), .reactivate_notice(react), .trigger_pulse(trig),
    .probe_active(active), .ecu_powered(powered), .power_save(save),
    .memory_write_protect(wprot), .memory_write_enable(wen), .ecu_reset_out(rst_out),
    .ecu_reset_oe(rst_oe));
  host_mcu_model mcu (.clk_sys(clk_sys), .host_bus(host_bus));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // trigger i also raises the notice sharing its offset
  function automatic logic [33:0] code(input int i);
    return {i == 1, i == 0, 32'h1 << i};
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] want, input string msg);
    total_checks++;
    if (got !== want) begin
      err_total++;
      $display("CHECK FAILED %0t: %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // strap and segment change only under reset
  task automatic do_reset(input logic [1:0] s);
    rst_n = 1'b0;
    strap = s;
    seg = SEG_HIGH_W'(rnd());
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
  endtask
  // bounded wait on the ecu reset drive; n counts cycles spent
  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while (rst_oe !== lvl) begin
      @(posedge clk_sys) #1;
      n++;
      if (n > 400) begin
        chk(1'b0, 1'b1, "ecu reset wait expired");
        print_verdict();
      end
    end
  endtask

  // ------------------------------------------------------------
  // watcher: every pulse takes the oldest expectation
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (wen === 1'b1) we_cnt++;
    if ({deact, react, trig} !== '0) begin
      if (exp_q.size() == 0) chk(1'b1, 1'b0, "unexpected pulse");
      else chk({deact, react, trig}, exp_q.pop_front(), "pulse mismatch");
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    int i;
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      wait_oe(1'b0, n);
      chk(34'(n >= 295 && n <= 310), 1'b1, "init hold length");
      // hit every select line; only the strapped one may answer
      for (int k = 0; k < 4; k++) begin
        i = int'(rnd() % 32);
        if (k == s) exp_q.push_back(code(i));
        mcu.write_cycle(4'h8 >> k, {seg, 8'(i * 4)});
        chk(34'(sel), 34'(k == s), "select response");
      end
      mcu.write_cycle(4'h8 >> s, {~seg, DEACTIVATE_OFFSET});
    end
    exp_q.push_back(code(1));
    mcu.write_cycle(4'h1, {seg, DEACTIVATE_OFFSET});
    @(posedge clk_sys) #1;
    chk(active, 1'b0, "active after deactivate");
    exp_q.push_back(code(0));
    mcu.write_cycle(4'h1, {seg, REACTIVATE_OFFSET});
    @(posedge clk_sys) #1;
    chk(active, 1'b1, "active after reactivate");
    // hard reset low, power-on reset low, then neither
    for (int k = 0; k < 3; k++) begin
      {por_n, hard_n} = ~(2'h1 << k);
      n = we_cnt;
      i = int'(rnd() % 32);
      exp_q.push_back(code(i));
      mcu.write_cycle(4'h1, {seg, 8'(i * 4)});
      @(posedge clk_sys) #1;
      chk(wprot, k < 2, "write protect level");
      chk(34'(we_cnt - n), k == 2, "qualified write count");
    end
    {supply, tool_on} = 2'h0;
    repeat (12) @(posedge clk_sys);
    #1 chk({powered, save, rst_oe}, 3'h3, "save mode entry");
    supply = 1'b1;
    wait_oe(1'b0, n);
    chk({powered, save, n > 290}, 3'h5, "save mode exit");
    // tool command, then internal failure
    for (int k = 0; k < 2; k++) begin
      {tool_req, fail} = 2'h2 >> k;
      @(posedge clk_sys) #1;
      chk(rst_oe, 1'b1, "commanded ecu reset");
      {tool_req, fail} = 2'h0;
      wait_oe(1'b0, n);
    end
    repeat (3) @(posedge clk_sys);
    chk(34'(exp_q.size()), 34'h0, "pulse never seen");
    print_verdict();
  end
endmodule // emulator_probe_ecu_port_control_tb_top
